// ---- hdl/fsog_top.sv ----
// Output clock gating and frame sync generation with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "fsog_cfg.svh"

module fsog_top #(
  parameter int FRAME_CYCLES = `FSOG_FRAME_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic frameSyncInput,
  input wire logic inputElevenSelected,
  input wire logic auxPathFail,
  input wire logic portThreeTick,
  output logic [6:0] portRun,
  output logic [6:0] portHoldLevel,
  output logic auxPortARun,
  output logic auxPortBRun,
  output logic frameSyncOut,
  output logic multiframeSyncOut,
  output logic syncAlarmLive,
  output logic syncIrq
);

  localparam logic [15:0] PERIOD = 16'(FRAME_CYCLES);
  localparam logic [15:0] HALF = 16'(FRAME_CYCLES / 2);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  fsog_pkg::fsog_bus_req_t busReq;
  logic [31:0] dividerReg;
  logic [31:0] portSrcReg;
  logic [3:0] auxReg;
  logic [6:0] fsCfg;
  logic [9:0] syncCfg;
  logic syncAlarmFlag;
  logic syncIrqEnable;
  logic [31:0] next_rdata;
  logic addrTaken;
  logic flagClear;

  assign addrTaken = hsel && htrans[1] && hready;
  assign flagClear = busReq.sel && busReq.write && (busReq.addr == `FSOG_ADDR_INTSTS) && hwdata[0];

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      `FSOG_ADDR_DIVIDER: next_rdata = dividerReg;
      `FSOG_ADDR_PORTSRC: next_rdata = portSrcReg;
      `FSOG_ADDR_AUX: next_rdata = {28'h0000000, auxReg};
      `FSOG_ADDR_FSCFG: next_rdata = {25'h0000000, fsCfg};
      `FSOG_ADDR_SYNCCFG: next_rdata = {22'h000000, syncCfg};
      `FSOG_ADDR_STATUS: next_rdata = {31'h00000000, syncAlarmLive};
      `FSOG_ADDR_INTSTS: next_rdata = {31'h00000000, syncAlarmFlag};
      `FSOG_ADDR_INTEN: next_rdata = {31'h00000000, syncIrqEnable};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busReq <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      busReq.sel <= addrTaken;
      busReq.addr <= haddr[7:0];
      busReq.write <= hwrite;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrTaken && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dividerReg <= `FSOG_RST_DIVIDER;
      portSrcReg <= `FSOG_RST_PORTSRC;
      auxReg <= `FSOG_RST_AUX;
      fsCfg <= `FSOG_RST_FSCFG;
      syncCfg <= `FSOG_RST_SYNCCFG;
      syncIrqEnable <= 1'b0;
    end else if (busReq.sel && busReq.write) begin
      unique case (busReq.addr)
        `FSOG_ADDR_DIVIDER: dividerReg <= {4'h0, hwdata[27:0]};
        `FSOG_ADDR_PORTSRC: portSrcReg <= {9'h000, hwdata[22:16], 2'b00, hwdata[13:0]};
        `FSOG_ADDR_AUX: auxReg <= hwdata[3:0];
        `FSOG_ADDR_FSCFG: fsCfg <= hwdata[6:0];
        `FSOG_ADDR_SYNCCFG: syncCfg <= {hwdata[9:8], 2'b00, hwdata[5:4], 1'b0, hwdata[2:0]};
        `FSOG_ADDR_INTEN: syncIrqEnable <= hwdata[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output port gating
  // ----------------------------------------------------------------
  fsog_pkg::fsog_port_cfg_t portCfg [7];

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      portCfg[i].code = dividerReg[4 * i +: 4];
      portCfg[i].family = fsog_pkg::fsog_family_t'(portSrcReg[2 * i +: 2]);
      portCfg[i].auxSource = portSrcReg[`FSOG_PORTSRC_AUX_LSB + i];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portRun <= 7'h00;
      portHoldLevel <= 7'h00;
    end else begin
      for (int i = 0; i < 7; i++) begin
        portHoldLevel[i] <= (portCfg[i].code == `FSOG_CODE_OFF_HIGH);
        portRun[i] <= !((portCfg[i].code == `FSOG_CODE_OFF_LOW) || (portCfg[i].code == `FSOG_CODE_OFF_HIGH))
          && !((i != `FSOG_DIFF_PORT_A) && (i != `FSOG_DIFF_PORT_B) && (portCfg[i].family == fsog_pkg::FSOG_FAM_SONET)
               && ((portCfg[i].code == `FSOG_CODE_622) || (portCfg[i].code == `FSOG_CODE_311)))
          && !(portCfg[i].auxSource && (portCfg[i].family == fsog_pkg::FSOG_FAM_RADIO)
               && (portCfg[i].code >= `FSOG_CODE_RADIO_FIRST) && (portCfg[i].code <= `FSOG_CODE_RADIO_LAST));
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      auxPortARun <= 1'b0;
      auxPortBRun <= 1'b0;
    end else begin
      auxPortARun <= auxReg[`FSOG_AUX_A_EN] && !(auxReg[`FSOG_AUX_A_GATE] && auxPathFail);
      auxPortBRun <= auxReg[`FSOG_AUX_B_EN] && !(auxReg[`FSOG_AUX_B_GATE] && auxPathFail);
    end
  end

  // ----------------------------------------------------------------
  // Sync input sampling and deviation monitor
  // ----------------------------------------------------------------
  logic [3:0] syncTaps;
  logic sampledSync;
  logic sampledPrev;
  logic syncEdge;
  logic [15:0] frameCnt;
  logic [1:0] frameIdx;
  logic [15:0] deviation;
  logic edgeExceeds;
  logic edgeSeen;
  logic frameExceeds;
  logic syncActive;
  logic realign;
  logic frameStart;

  always_comb begin
    unique case (syncCfg[`FSOG_SYNC_PHASE_LSB +: 2])
      2'd0: sampledSync = syncTaps[2];
      2'd1: sampledSync = syncTaps[3];
      2'd2: sampledSync = syncTaps[1];
      2'd3: sampledSync = syncTaps[0];
    endcase
  end

  assign syncEdge = sampledPrev && !sampledSync;
  assign deviation = (frameCnt < HALF) ? frameCnt : 16'(PERIOD - frameCnt);
  assign edgeExceeds = deviation > {13'h0000, syncCfg[`FSOG_SYNC_LIMIT_MSB:0]};
  assign syncActive = !syncAlarmLive && syncCfg[`FSOG_SYNC_EN]
    && (!syncCfg[`FSOG_SYNC_AUTO] || inputElevenSelected);
  assign realign = syncActive && syncEdge && !edgeExceeds;
  assign frameStart = (frameCnt == 16'h0000) || (realign && (frameCnt >= HALF));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncTaps <= 4'h0;
      sampledPrev <= 1'b0;
    end else begin
      syncTaps <= {syncTaps[2:0], frameSyncInput};
      sampledPrev <= sampledSync;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      edgeSeen <= 1'b0;
      frameExceeds <= 1'b0;
      syncAlarmLive <= 1'b0;
    end else if (frameStart) begin
      edgeSeen <= 1'b0;
      frameExceeds <= 1'b0;
      if (edgeSeen || syncEdge) begin
        syncAlarmLive <= syncEdge ? edgeExceeds : frameExceeds;
      end
    end else if (syncEdge) begin
      edgeSeen <= 1'b1;
      frameExceeds <= edgeExceeds;
    end
  end

  // ----------------------------------------------------------------
  // Alarm event flag and interrupt request
  // ----------------------------------------------------------------
  logic alarmPrev;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarmPrev <= 1'b0;
      syncAlarmFlag <= 1'b0;
      syncIrq <= 1'b0;
    end else begin
      alarmPrev <= syncAlarmLive;
      if (syncAlarmLive && !alarmPrev) begin
        syncAlarmFlag <= 1'b1;
      end else if (flagClear) begin
        syncAlarmFlag <= 1'b0;
      end
      syncIrq <= syncAlarmFlag && syncIrqEnable;
    end
  end

  // ----------------------------------------------------------------
  // Frame sync output generation
  // ----------------------------------------------------------------
  logic fsPulse;
  logic mfsPulse;
  logic fsStart;
  logic mfsStart;
  logic fsWave;
  logic mfsWave;
  logic [15:0] tickGap;
  logic [15:0] tickPeriod;
  logic [15:0] fsLeft;
  logic [15:0] mfsLeft;

  assign fsStart = fsCfg[`FSOG_PUL_POS] ? frameStart : (frameCnt == HALF);
  assign mfsStart = frameStart && (frameIdx == (fsCfg[`FSOG_PUL_POS] ? 2'd3 : 2'd1));
  assign fsPulse = (fsLeft != 16'h0000);
  assign mfsPulse = (mfsLeft != 16'h0000);
  assign fsWave = fsCfg[`FSOG_FS_PUL] ? fsPulse : (frameCnt < HALF);
  assign mfsWave = fsCfg[`FSOG_MFS_PUL] ? mfsPulse : (frameIdx < 2'd2);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frameCnt <= 16'h0001;
      frameIdx <= 2'd0;
    end else begin
      if (realign) begin
        frameCnt <= 16'h0001;
      end else if (frameCnt == 16'(PERIOD - 16'h0001)) begin
        frameCnt <= 16'h0000;
      end else begin
        frameCnt <= frameCnt + 16'h0001;
      end
      if (frameStart) begin
        frameIdx <= frameIdx + 2'd1;
      end
    end
  end

  // The pulse length copies the last measured spacing of the port three ticks, so it spans one whole period.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickGap <= 16'h0001;
      tickPeriod <= 16'h0001;
    end else if (portThreeTick) begin
      tickGap <= 16'h0001;
      tickPeriod <= tickGap;
    end else if (tickGap != 16'hffff) begin
      tickGap <= tickGap + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fsLeft <= 16'h0000;
      mfsLeft <= 16'h0000;
    end else begin
      if (fsStart) begin
        fsLeft <= tickPeriod;
      end else if (fsPulse) begin
        fsLeft <= fsLeft - 16'h0001;
      end
      if (mfsStart) begin
        mfsLeft <= tickPeriod;
      end else if (mfsPulse) begin
        mfsLeft <= mfsLeft - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frameSyncOut <= 1'b0;
      multiframeSyncOut <= 1'b0;
    end else begin
      frameSyncOut <= fsCfg[`FSOG_FS_EN] && (fsWave ^ fsCfg[`FSOG_FS_INV]);
      multiframeSyncOut <= fsCfg[`FSOG_MFS_EN] && (mfsWave ^ fsCfg[`FSOG_MFS_INV]);
    end
  end

endmodule

// ---- inc/fsog_cfg.svh ----
// Register map, field positions, reset values and timing counts for the frame sync block.
`ifndef FSOG_CFG_SVH
`define FSOG_CFG_SVH

`define FSOG_ADDR_DIVIDER 8'h00
`define FSOG_ADDR_PORTSRC 8'h04
`define FSOG_ADDR_AUX 8'h08
`define FSOG_ADDR_FSCFG 8'h0c
`define FSOG_ADDR_SYNCCFG 8'h10
`define FSOG_ADDR_STATUS 8'h14
`define FSOG_ADDR_INTSTS 8'h18
`define FSOG_ADDR_INTEN 8'h1c

`define FSOG_RST_DIVIDER 32'h0000_0000
`define FSOG_RST_PORTSRC 32'h0000_0000
`define FSOG_RST_AUX 4'h0
`define FSOG_RST_FSCFG 7'h00
`define FSOG_RST_SYNCCFG 10'h000

`define FSOG_PORTSRC_AUX_LSB 16
`define FSOG_AUX_A_EN 0
`define FSOG_AUX_A_GATE 1
`define FSOG_AUX_B_EN 2
`define FSOG_AUX_B_GATE 3
`define FSOG_FS_EN 0
`define FSOG_MFS_EN 1
`define FSOG_FS_INV 2
`define FSOG_MFS_INV 3
`define FSOG_FS_PUL 4
`define FSOG_MFS_PUL 5
`define FSOG_PUL_POS 6
`define FSOG_SYNC_LIMIT_MSB 2
`define FSOG_SYNC_PHASE_LSB 4
`define FSOG_SYNC_EN 8
`define FSOG_SYNC_AUTO 9

`define FSOG_CODE_OFF_LOW 4'h0
`define FSOG_CODE_OFF_HIGH 4'hf
`define FSOG_CODE_622 4'h1
`define FSOG_CODE_311 4'h2
`define FSOG_CODE_RADIO_FIRST 4'h9
`define FSOG_CODE_RADIO_LAST 4'hd
`define FSOG_DIFF_PORT_A 5
`define FSOG_DIFF_PORT_B 6

`define FSOG_CLK_PERIOD_PS 5000
`define FSOG_FRAME_PERIOD_NS 125000
`define FSOG_FRAME_CYCLES ((`FSOG_FRAME_PERIOD_NS * 1000) / `FSOG_CLK_PERIOD_PS)

`endif

// ---- inc/fsog_pkg.sv ----
// Types shared by the frame sync and output gating block.
package fsog_pkg;

  typedef enum logic [1:0] {
    FSOG_FAM_SONET,
    FSOG_FAM_RADIO,
    FSOG_FAM_OTHER,
    FSOG_FAM_SPARE
  } fsog_family_t;

  typedef struct packed {
    logic [3:0] code;
    fsog_family_t family;
    logic auxSource;
  } fsog_port_cfg_t;

  typedef struct packed {
    logic sel;
    logic [7:0] addr;
    logic write;
  } fsog_bus_req_t;

endpackage

// ---- verification/fsog_bench.sv ----
// Self-checking testbench for the frame sync and output gating block.
`timescale 1ns/1ps
module fsog_bench;
  logic sys_clk;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic inputElevenSelected = 1'b0;
  logic auxPathFail = 1'b0;
  logic portThreeTick = 1'b0;
  logic active = 1'b0;
  logic [7:0] shift = 8'h00;
  logic hreadyout, hresp, frameSyncInput, auxPortARun, auxPortBRun;
  logic frameSyncOut, multiframeSyncOut, syncAlarmLive, syncIrq;
  logic [31:0] hrdata;
  logic [6:0] portRun, portHoldLevel;
  int cyc = 0;
  int miscompares = 0;
  int n_tests = 0;
  int h, w, hm, wm;
  fsog_top #(.FRAME_CYCLES(64)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .frameSyncInput(frameSyncInput),
    .inputElevenSelected(inputElevenSelected), .auxPathFail(auxPathFail), .portThreeTick(portThreeTick),
    .portRun(portRun), .portHoldLevel(portHoldLevel), .auxPortARun(auxPortARun), .auxPortBRun(auxPortBRun),
    .frameSyncOut(frameSyncOut), .multiframeSyncOut(multiframeSyncOut), .syncAlarmLive(syncAlarmLive),
    .syncIrq(syncIrq));
  fsog_sync_src #(.PERIOD(64)) src (.sys_clk(sys_clk), .reset_n(reset_n), .active(active), .shift(shift),
    .frameSyncInput(frameSyncInput));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= reset_n ? cyc + 1 : 0;
    portThreeTick <= reset_n && (cyc % 4 == 3);
  end
  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  function automatic logic [31:0] b(input logic v);
    return {31'h0, v};
  endfunction
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) begin
        miscompares++;
        stop_test;
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic at(input int m, input int r);
    int k;
    k = 0;
    while (cyc % m != r) begin
      k++;
      if (k > m) begin
        miscompares++;
        stop_test;
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic count;
    h = 0;
    w = 0;
    hm = 0;
    wm = 0;
    repeat (256) begin
      @(posedge sys_clk);
      h += frameSyncOut;
      w += frameSyncOut && (cyc % 64 >= 24) && (cyc % 64 < 40);
      hm += multiframeSyncOut;
      wm += multiframeSyncOut && (cyc % 256 >= 96) && (cyc % 256 < 160);
    end
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    wr(8'h14, 32'h1);
    rd(8'h14, 32'h0);
    $display("registers done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0212310f);
    check({25'h0, portRun}, 32'h68);
    check({25'h0, portHoldLevel}, 32'h01);
    wr(8'h04, 32'h40);
    wr(8'h00, 32'h9000);
    check({25'h0, portRun}, 32'h08);
    wr(8'h04, 32'h80040);
    check({25'h0, portRun}, 32'h00);
    $display("dividers done");
    for (int i = 0; i < 8; i++) begin
      auxPathFail <= i[2];
      wr(8'h08, {28'h0, i[1], i[0], i[1], i[0]});
      check(b(auxPortARun), b(i[0] & ~(i[1] & i[2])));
      check(b(auxPortBRun), b(i[0] & ~(i[1] & i[2])));
    end
    $display("aux ports done");
    for (int v = 0; v < 2; v++) begin
      wr(8'h0c, v[0] ? 32'h0f : 32'h03);
      at(256, 48);
      check(b(frameSyncOut), b(v[0]));
      at(256, 80);
      check(b(frameSyncOut), b(!v[0]));
      check(b(multiframeSyncOut), b(!v[0]));
      at(256, 208);
      check(b(multiframeSyncOut), b(v[0]));
    end
    for (int p = 0; p < 2; p++) begin
      wr(8'h0c, p[0] ? 32'h73 : 32'h33);
      at(256, 8);
      count;
      check(h, 32'h10);
      check(hm, 32'h4);
      check(b(w > 0), b(!p[0]));
      check(b(wm > 0), b(!p[0]));
    end
    wr(8'h0c, 32'h0);
    count;
    check(h, 32'h0);
    check(hm, 32'h0);
    $display("frame sync outputs done");
    wr(8'h10, 32'h107);
    active <= 1'b1;
    inputElevenSelected <= 1'b1;
    repeat (256) @(posedge sys_clk);
    wr(8'h18, 32'h1);
    for (int ph = 0; ph < 4; ph++) begin
      wr(8'h10, 32'h307 | (ph << 4));
      repeat (128) @(posedge sys_clk);
      rd(8'h14, 32'h0);
    end
    rd(8'h18, 32'h0);
    wr(8'h1c, 32'h1);
    shift <= 8'd20;
    repeat (256) @(posedge sys_clk);
    rd(8'h14, 32'h1);
    rd(8'h18, 32'h1);
    check(b(syncIrq), 32'h1);
    wr(8'h18, 32'h1);
    check(b(syncIrq), 32'h0);
    check(b(syncAlarmLive), 32'h1);
    shift <= 8'd0;
    repeat (256) @(posedge sys_clk);
    rd(8'h14, 32'h0);
    $display("sync alarm done");
    stop_test;
  end
endmodule

// ---- verification/fsog_chk.sv ----
// Port-level assertions for the frame sync and output gating block.
`timescale 1ns/1ps
module fsog_chk #(
  parameter int FRAME_CYCLES = 64
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic auxPathFail,
  input wire logic [6:0] portRun,
  input wire logic [6:0] portHoldLevel,
  input wire logic auxPortARun,
  input wire logic frameSyncOut,
  input wire logic syncAlarmLive,
  input wire logic syncIrq
);
  // ----------------------------------------
  // Shadow copies of the written settings
  // ----------------------------------------
  logic wPend;
  logic [7:0] wAddr;
  logic [27:0] div;
  logic [3:0] aux;
  logic fsEn;
  logic irqEn;
  logic [6:0] stopHi;
  logic [6:0] stopLo;
  logic [6:0] fastBad;
  logic [13:0] fam;
  logic [6:0] auxSrc;
  logic [6:0] radioBad;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wPend <= 1'b0;
      wAddr <= 8'h00;
    end else begin
      wPend <= hsel && htrans[1] && hready && hwrite;
      wAddr <= haddr[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 28'h0000000;
      aux <= 4'h0;
      fam <= 14'h0000;
      auxSrc <= 7'h00;
      fsEn <= 1'b0;
      irqEn <= 1'b0;
    end else if (wPend) begin
      if (wAddr == 8'h00) div <= hwdata[27:0];
      if (wAddr == 8'h04) fam <= hwdata[13:0];
      if (wAddr == 8'h04) auxSrc <= hwdata[22:16];
      if (wAddr == 8'h08) aux <= hwdata[3:0];
      if (wAddr == 8'h0c) fsEn <= hwdata[0];
      if (wAddr == 8'h1c) irqEn <= hwdata[0];
    end
  end
  // The port flags lag one edge, matching the output register after the setting.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopHi <= 7'h00;
      stopLo <= 7'h7f;
      fastBad <= 7'h00;
      radioBad <= 7'h00;
    end else begin
      for (int i = 0; i < 7; i++) begin
        stopHi[i] <= div[4*i +: 4] == 4'hf;
        stopLo[i] <= div[4*i +: 4] == 4'h0;
        fastBad[i] <= (i < 5) && (fam[2*i +: 2] == 2'b00) && (div[4*i +: 4] inside {4'h1, 4'h2});
        radioBad[i] <= auxSrc[i] && (fam[2*i +: 2] == 2'b01) && (div[4*i +: 4] inside {[4'h9:4'hd]});
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_bus_okay; hreadyout && !hresp; endproperty
  property p_code_stop; (portRun & (stopHi | stopLo)) == 7'h00 && (portHoldLevel & stopHi) == stopHi; endproperty
  property p_fast_ports; (portRun & fastBad) == 7'h00; endproperty
  property p_radio_main; (portRun & radioBad) == 7'h00; endproperty
  property p_aux_off; !aux[0] |=> !auxPortARun; endproperty
  property p_aux_run; aux[0] && !aux[1] |=> auxPortARun; endproperty
  property p_aux_fail; aux[1:0] == 2'b11 && auxPathFail |=> !auxPortARun; endproperty
  property p_fs_off; !fsEn |=> !frameSyncOut; endproperty
  property p_irq_off; !irqEn |=> !syncIrq; endproperty
  property p_irq_rise; $rose(syncAlarmLive) && irqEn |-> ##[0:3] syncIrq; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
  a_code_stop: assert property (p_code_stop) else $error("stopped port runs or holds wrong level");
  a_fast_ports: assert property (p_fast_ports) else $error("fast rate on a single ended port");
  a_radio_main: assert property (p_radio_main) else $error("radio rate runs from the auxiliary path");
  a_aux_off: assert property (p_aux_off) else $error("disabled aux port runs");
  a_aux_run: assert property (p_aux_run) else $error("ungated aux port stopped");
  a_aux_fail: assert property (p_aux_fail) else $error("gated aux port runs on failure");
  a_fs_off: assert property (p_fs_off) else $error("disabled frame sync output high");
  a_irq_off: assert property (p_irq_off) else $error("masked alarm raised request");
  a_irq_rise: assert property (p_irq_rise) else $error("alarm gave no request");
  c_alarm: cover property ($rose(syncAlarmLive));
  c_irq: cover property ($rose(syncIrq));
  c_aux_fail: cover property (aux[1:0] == 2'b11 && auxPathFail);
endmodule
bind fsog_top fsog_chk #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .auxPathFail(auxPathFail), .portRun(portRun),
  .portHoldLevel(portHoldLevel), .auxPortARun(auxPortARun), .frameSyncOut(frameSyncOut),
  .syncAlarmLive(syncAlarmLive), .syncIrq(syncIrq));

// ---- verification/fsog_sync_src.sv ----
// External frame sync source model.
`timescale 1ns/1ps
module fsog_sync_src #(
  parameter int PERIOD = 64
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic active,
  input wire logic [7:0] shift,
  output logic frameSyncInput
);
  int cnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      frameSyncInput <= 1'b1;
    end else begin
      cnt <= (cnt + 1) % PERIOD;
      // The falling edge sits at position shift; when idle the level stands still.
      if (active) frameSyncInput <= ((cnt - int'(shift) + PERIOD) % PERIOD) >= PERIOD / 2;
    end
  end
endmodule
